// >>> rtl/wdc_top.sv
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module wdc_top
  import wdc_pkg::*;
#(
  parameter logic [31:0] BASE_CYC = BASE_CYC_DEF
)
(
  input wire logic pclk, // System clock, 50 MHz
  input wire logic presetn, // External hardware reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic supply_monitor_irq, // Supply monitor interrupt pin
  output logic sys_reset_req, // Watchdog system reset pulse
  output logic core_irq, // Watchdog core interrupt pulse
  output logic irq // Masked event interrupt level
);
  logic unlock_r;
  logic arm_r;
  logic status_r;
  logic resp_r;
  logic [3:0] pre_r;
  logic [EVT_W-1:0] istat_r;
  logic [EVT_W-1:0] mask_r;
  logic sm_meta_r;
  logic sm_sync_r;
  logic expire;
  logic [31:0] rd_mux;
  logic [EVT_W-1:0] istat_nxt;

  // APB decode: a transfer completes at the edge where pready is sampled high
  wire xfer_done = psel & penable & pready;
  wire ready_nxt = psel & penable & ~pready;
  wire wr_do = xfer_done & pwrite;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_istat = (paddr == ADDR_ISTAT);
  wire hit_imask = (paddr == ADDR_IMASK);
  wire unmapped = ~(hit_ctrl | hit_istat | hit_imask);
  wire ctrl_wr = wr_do & hit_ctrl;
  wire unlock_set = ctrl_wr & ~unlock_r & pwdata[BIT_UNLOCK];
  wire ctrl_take = ctrl_wr & unlock_r;
  wire ctrl_locked = ctrl_wr & ~unlock_r & ~pwdata[BIT_UNLOCK];
  wire rearm = ctrl_take & pwdata[BIT_ARM];
  wire wdog_reset = expire & ~resp_r;
  wire wdog_intr = expire & resp_r;
  wire [31:0] limit = BASE_CYC << pre_r;

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[PRE_MSB:PRE_LSB] = pre_r;
      rd_mux[BIT_RESP] = resp_r;
      rd_mux[BIT_STATUS] = status_r;
      rd_mux[BIT_ARM] = arm_r;
      rd_mux[BIT_UNLOCK] = unlock_r;
    end else if (hit_istat) begin
      rd_mux[EVT_W-1:0] = istat_r;
    end else if (hit_imask) begin
      rd_mux[EVT_W-1:0] = mask_r;
    end
  end

  // Sticky events: a new event wins over a write-one clear
  always_comb begin
    istat_nxt = istat_r;
    if (wr_do && hit_istat) begin
      istat_nxt = istat_r & ~pwdata[EVT_W-1:0];
    end
    if (expire) begin
      istat_nxt[EVT_TIMEOUT] = 1'b1;
    end
    if (ctrl_locked) begin
      istat_nxt[EVT_LOCKED] = 1'b1;
    end
  end

  // Supply monitor pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sm_meta_r <= 1'b0;
      sm_sync_r <= 1'b0;
    end else begin
      sm_meta_r <= supply_monitor_irq;
      sm_sync_r <= sm_meta_r;
    end
  end

  // APB answer: one wait state, registered data and error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= ready_nxt;
      pslverr <= ready_nxt & unmapped;
      if (ready_nxt && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Unlock: armed by one write, consumed by the very next transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r <= 1'b0;
    end else if (unlock_set) begin
      unlock_r <= 1'b1;
    end else if (xfer_done) begin
      unlock_r <= 1'b0;
    end
  end

  // Arm bit and control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_r <= 1'b0;
      resp_r <= 1'b0;
      pre_r <= PRE_RST;
    end else begin
      if (sm_sync_r || wdog_reset) begin
        arm_r <= 1'b0;
      end else if (ctrl_take) begin
        arm_r <= pwdata[BIT_ARM];
      end
      if (ctrl_take) begin
        resp_r <= pwdata[BIT_RESP];
        pre_r <= pwdata[PRE_MSB:PRE_LSB];
      end
    end
  end

  // Status flag: set by timeout, cleared by unlocked zero write only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 1'b0;
    end else if (expire) begin
      status_r <= 1'b1;
    end else if (ctrl_take && !pwdata[BIT_STATUS]) begin
      status_r <= 1'b0;
    end
  end

  // Timeout response and event interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_req <= 1'b0;
      core_irq <= 1'b0;
      istat_r <= {EVT_W{1'b0}};
      mask_r <= MASK_RST;
      irq <= 1'b0;
    end else begin
      sys_reset_req <= wdog_reset;
      core_irq <= wdog_intr;
      istat_r <= istat_nxt;
      if (wr_do && hit_imask) begin
        mask_r <= pwdata[EVT_W-1:0];
      end
      irq <= |(istat_nxt & ((wr_do && hit_imask) ? pwdata[EVT_W-1:0] : mask_r));
    end
  end

  // Timeout counter
  wdc_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .run(arm_r),
    .restart(rearm),
    .limit(limit),
    .expire(expire)
  );

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_unlock;
    ctrl_wr && !unlock_r && pwdata[BIT_UNLOCK];
  endsequence
  sequence s_consume;
    unlock_r && xfer_done;
  endsequence

  AST_RESP_IRQ: assert property (expire && resp_r |=> core_irq && !sys_reset_req)
    else $error("interrupt response missing");
  AST_RESP_RST: assert property (expire && !resp_r |=> sys_reset_req && !core_irq)
    else $error("reset response missing");
  AST_STATUS_SET: assert property (expire |=> status_r)
    else $error("status flag not set on timeout");
  AST_STATUS_HOLD: assert property (status_r && !ctrl_take |=> status_r)
    else $error("status flag cleared without write");
  AST_REARM: assert property (rearm && !sm_sync_r && !wdog_reset |=> arm_r && !expire)
    else $error("re-arm did not restart");
  AST_ARM_CLEAR: assert property (sm_sync_r || wdog_reset |=> !arm_r)
    else $error("arm bit not cleared");
  AST_LOCKED: assert property (ctrl_wr && !unlock_r |=> $stable(resp_r) && $stable(pre_r))
    else $error("locked control write took effect");
  AST_UNLOCK_SEQ: assert property (s_unlock |=> unlock_r)
    else $error("unlock not armed by unlock write");
  // Unlock window: held until the very next completed transfer, then spent
  AST_UNLOCK_HOLD: assert property (unlock_r && !xfer_done |=> unlock_r)
    else $error("unlock lost before next transfer");
  AST_UNLOCK_USE: assert property (s_consume |=> !unlock_r)
    else $error("unlock not consumed by next transfer");
  AST_LOCKED_EVT: assert property (ctrl_locked |=> istat_r[EVT_LOCKED])
    else $error("ignored control write not recorded");
  AST_STATUS_CLEAR: assert property (ctrl_take && !pwdata[BIT_STATUS] && !expire
    |=> !status_r)
    else $error("status flag not cleared by zero write");
  AST_ARM_HOLD: assert property (arm_r && !sm_sync_r && !wdog_reset && !ctrl_take
    |=> arm_r)
    else $error("arm bit cleared without cause");
  AST_EXPIRE_ARMED: assert property (expire |-> $past(arm_r) && !$past(rearm))
    else $error("timeout without armed counter");
endmodule : wdc_top
`default_nettype wire

// >>> rtl/wdc_pkg.sv
package wdc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ISTAT = 8'h04;
  localparam logic [7:0] ADDR_IMASK = 8'h08;
  // Control register field positions
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_ARM = 1;
  localparam int BIT_STATUS = 2;
  localparam int BIT_RESP = 3;
  localparam int PRE_LSB = 4;
  localparam int PRE_MSB = 7;
  // Event bits of the interrupt status and mask registers
  localparam int EVT_TIMEOUT = 0;
  localparam int EVT_LOCKED = 1;
  localparam int EVT_W = 2;
  // Reset values
  localparam logic [3:0] PRE_RST = 4'h0;
  localparam logic [EVT_W-1:0] MASK_RST = 2'h0;
  // Default base timeout in clock cycles, multiplied by two per prescale step
  localparam logic [31:0] BASE_CYC_DEF = 32'h0000_2000;
endpackage : wdc_pkg

// >>> rtl/wdc_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wdc_counter
  import wdc_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic run, // Watchdog armed
  input wire logic restart, // Clear the count
  input wire logic [31:0] limit, // Terminal count in cycles
  output logic expire // One-cycle timeout pulse
);
  logic [31:0] count_r;
  wire at_end = (count_r >= (limit - 32'h0000_0001));

  // Count ticks to the terminal count, then restart and flag expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 32'h0000_0000;
      expire <= 1'b0;
    end else if (restart || !run) begin
      count_r <= 32'h0000_0000;
      expire <= 1'b0;
    end else if (at_end) begin
      count_r <= 32'h0000_0000;
      expire <= 1'b1;
    end else begin
      count_r <= count_r + 32'h0000_0001;
      expire <= 1'b0;
    end
  end
endmodule : wdc_counter
`default_nettype wire

// >>> verif/wdc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module wdc_top_test;
  import wdc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, smon = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sys_reset_req, core_irq, irq;
  int fail_count = 0, n_tests = 0, n_rst = 0, n_cirq = 0, r0, c0;
  logic [31:0] rv;
  logic ev;
  wdc_top #(.BASE_CYC(32'h10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_monitor_irq(smon),
    .sys_reset_req(sys_reset_req), .core_irq(core_irq), .irq(irq));
  // Clock and pulse counters
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    if (sys_reset_req === 1'b1) n_rst++;
    if (core_irq === 1'b1) n_cirq++;
  end
  // Verdict and end of run
  task automatic test_done;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rv, e);
  endtask : rd
  // Unlocked control write
  task automatic uwr(input logic [31:0] d);
    apb(1, ADDR_CTRL, 32'h1);
    apb(1, ADDR_CTRL, d);
  endtask : uwr
  task automatic waitp(ref int c, input int b);
    for (int i = 0; i < 80 && c == b; i++) @(posedge pclk);
  endtask : waitp
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(ADDR_CTRL, 32'h0);
    apb(1, ADDR_CTRL, 32'h2);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_ISTAT, 32'h2);
    apb(1, ADDR_ISTAT, 32'h2);
    rd(ADDR_ISTAT, 32'h0);
    uwr(32'h22);
    rd(ADDR_CTRL, 32'h22);
    apb(1, ADDR_CTRL, 32'h0);
    rd(ADDR_CTRL, 32'h22);
    r0 = n_rst;
    repeat (4) uwr(32'h2);
    chk(n_rst, r0);
    c0 = n_cirq;
    waitp(n_rst, r0);
    chk(n_rst, r0 + 1);
    chk(n_cirq, c0);
    rd(ADDR_CTRL, 32'h4);
    apb(1, ADDR_ISTAT, 32'h3);
    apb(1, ADDR_IMASK, 32'h1);
    chk(irq, 1'b0);
    r0 = n_rst;
    uwr(32'hA);
    rd(ADDR_CTRL, 32'hA);
    waitp(n_cirq, c0);
    chk(n_cirq, c0 + 1);
    chk(n_rst, r0);
    rd(ADDR_CTRL, 32'hE);
    chk(irq, 1'b1);
    uwr(32'h8);
    rd(ADDR_CTRL, 32'h8);
    apb(1, ADDR_ISTAT, 32'h1);
    rd(ADDR_ISTAT, 32'h0);
    chk(irq, 1'b0);
    uwr(32'h2);
    smon <= 1;
    repeat (4) @(posedge pclk);
    smon <= 0;
    rd(ADDR_CTRL, 32'h0);
    rd(8'h0C, 32'h0);
    chk(ev, 1'b1);
    r0 = n_rst;
    uwr(32'h2);
    waitp(n_rst, r0);
    rd(ADDR_CTRL, 32'h4);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(ADDR_CTRL, 32'h0);
    test_done();
  end
  // Watchdog on the bench itself
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule : wdc_top_test
`default_nettype wire
